// file: rtl/bax_pkg.sv
// package: operation codes, field layouts and constants for the byte execute datapath
package bax_pkg;
  localparam int BAX_DATA_W = 8;
  localparam int BAX_ADDR_W = 7;
  localparam int BAX_PC_W = 13;
  localparam logic [7:0] BAX_ACC_RST = 8'h00;
  localparam logic [12:0] BAX_PC_RST = 13'h0000;
  localparam logic [7:0] BAX_NIB_LO_MSB = 8'h03;
  // operation selector
  typedef enum logic [4:0] {
    BAX_OP_NOP = 5'h00,
    BAX_OP_DEC = 5'h01,
    BAX_OP_INC = 5'h02,
    BAX_OP_DEC_SKIP = 5'h03,
    BAX_OP_INC_SKIP = 5'h04,
    BAX_OP_OR_IMM = 5'h05,
    BAX_OP_OR_REG = 5'h06,
    BAX_OP_LOAD_IMM = 5'h07,
    BAX_OP_STORE_ACC = 5'h08,
    BAX_OP_COPY_REG = 5'h09,
    BAX_OP_ROT_LEFT = 5'h0a,
    BAX_OP_ROT_RIGHT = 5'h0b,
    BAX_OP_RET_IMM = 5'h0c,
    BAX_OP_RETURN = 5'h0d,
    BAX_OP_RET_IRQ = 5'h0e,
    BAX_OP_STANDBY = 5'h0f,
    BAX_OP_IMM_SUB = 5'h10,
    BAX_OP_REG_SUB = 5'h11,
    BAX_OP_XOR_IMM = 5'h12,
    BAX_OP_XOR_REG = 5'h13,
    BAX_OP_SWAP = 5'h14
  } bax_op_t;
  // one instruction as presented by the decoder
  typedef struct packed {
    bax_op_t op;
    logic [6:0] addr;
    logic to_reg;
    logic [7:0] imm;
    logic is_io;
  } bax_instr_t;
  // status bits kept by the datapath
  typedef struct packed {
    logic watchdog_expiry_n;
    logic power_down_n;
    logic result_null_flag;
    logic half_carry;
    logic carry;
  } bax_status_t;
  localparam bax_status_t BAX_STATUS_RST = 5'b11000;
  // execute states, one-hot
  typedef enum logic [2:0] {
    BAX_ST_RUN = 3'b001,
    BAX_ST_FLUSH = 3'b010,
    BAX_ST_HALT = 3'b100
  } bax_state_t;
endpackage

// file: rtl/bax_byte_alu.sv
// byte alu execute stage: one instruction per cycle, two for returns and taken skips
`timescale 1ns/100ps
// Overview of operation
// (RULE1) decrement: register minus one to selected target, zero flag only
// (RULE2) increment: register plus one to selected target, zero flag only
// (RULE3) skip forms write like plain ones, keep status, zero result flushes next
// (RULE4) target bit 0 writes accumulator, 1 writes the addressed register
// (RULE5) or immediate: accumulator or literal into accumulator, zero flag
// (RULE6) or register: accumulator or register to target, zero flag
// (RULE7) load immediate: literal into accumulator, status untouched
// (RULE8) store accumulator: accumulator into register, status untouched
// (RULE9) copy register to target, zero flag, also for self write test
// (RULE10) rotate left through carry, old bit 7 becomes carry
// (RULE11) rotate right through carry, old bit 0 becomes carry
// (RULE12) return with literal: accumulator gets literal, pc from stack head, two cycles
// (RULE13) return: pop stack, pc from stack head, two cycles, no status change
// (RULE14) standby clears power down, sets expiry, clears watchdog, halts
// (RULE15) literal minus accumulator into accumulator, updates carry, half carry, zero
// (RULE16) register minus accumulator to target, updates carry, half carry, zero
// (RULE17) xor immediate into accumulator, zero flag
// (RULE18) xor register to target, zero flag
// (RULE19) swap nibbles of register to target, no status change
// (RULE20) pc change or true test takes two cycles, second is a nop
// (RULE21) read-modify-write of an io register uses pin values
// (RULE22) interrupt return: pc from stack head, pop, set global enable
// (RULE23) zero flag set when eight bit result is zero, else cleared
// (RULE24) other operations take one cycle, nop changes no state
module bax_byte_alu
  import bax_pkg::*;
#(
  parameter int DATA_W = BAX_DATA_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire bax_instr_t instr_i,
  input wire logic [7:0] reg_rd_data_i,
  input wire logic [7:0] pin_rd_data_i,
  input wire logic [12:0] stack_head_i,
  input wire logic wake_i,
  output logic instr_ready_o,
  output logic [7:0] accumulator_reg_o,
  output bax_status_t status_o,
  output logic reg_wr_en_o,
  output logic [6:0] reg_wr_addr_o,
  output logic [7:0] reg_wr_data_o,
  output logic pc_load_o,
  output logic [12:0] pc_value_o,
  output logic stack_pop_o,
  output logic global_irq_enable_o,
  output logic watchdog_clear_o,
  output logic halted_o
);

  // datapath is byte wide only
  if (DATA_W != 8) begin : g_bad_width
    $error("bax_byte_alu supports only DATA_W of 8");
  end

  bax_state_t state;
  bax_state_t next_state;
  logic [7:0] acc;
  bax_status_t st;

  // operand fetch: io registers are read from the pins
  wire logic [7:0] opnd = instr_i.is_io ? pin_rd_data_i : reg_rd_data_i; // RULE21
  wire logic fire = instr_valid_i && (state == BAX_ST_RUN);
  wire bax_op_t op = instr_i.op;

  wire logic [8:0] sub_imm = {1'b0, instr_i.imm} + {1'b0, ~acc} + 9'h001; // RULE15
  wire logic [8:0] sub_reg = {1'b0, opnd} + {1'b0, ~acc} + 9'h001; // RULE16
  wire logic [4:0] hc_imm = {1'b0, instr_i.imm[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire logic [4:0] hc_reg = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  // result selection
  logic [7:0] res;
  logic res_ok;
  always_comb begin
    res = 8'h00;
    res_ok = 1'b1;
    case (op)
      BAX_OP_DEC, BAX_OP_DEC_SKIP: res = opnd - 8'h01; // RULE1 RULE3
      BAX_OP_INC, BAX_OP_INC_SKIP: res = opnd + 8'h01; // RULE2 RULE3
      BAX_OP_OR_IMM: res = acc | instr_i.imm; // RULE5
      BAX_OP_OR_REG: res = acc | opnd; // RULE6
      BAX_OP_LOAD_IMM, BAX_OP_RET_IMM: res = instr_i.imm; // RULE7 RULE12
      BAX_OP_STORE_ACC: res = acc; // RULE8
      BAX_OP_COPY_REG: res = opnd; // RULE9
      BAX_OP_ROT_LEFT: res = {opnd[6:0], st.carry}; // RULE10
      BAX_OP_ROT_RIGHT: res = {st.carry, opnd[7:1]}; // RULE11
      BAX_OP_IMM_SUB: res = sub_imm[7:0]; // RULE15
      BAX_OP_REG_SUB: res = sub_reg[7:0]; // RULE16
      BAX_OP_XOR_IMM: res = acc ^ instr_i.imm; // RULE17
      BAX_OP_XOR_REG: res = acc ^ opnd; // RULE18
      BAX_OP_SWAP: res = {opnd[3:0], opnd[7:4]}; // RULE19
      default: res_ok = 1'b0;
    endcase
  end

  wire logic res_zero = (res == 8'h00); // RULE23
  wire logic lit_op = (op == BAX_OP_OR_IMM) || (op == BAX_OP_LOAD_IMM) || (op == BAX_OP_RET_IMM)
    || (op == BAX_OP_IMM_SUB) || (op == BAX_OP_XOR_IMM);
  // target decode: literal forms always land in the accumulator, store always in the file
  wire logic to_file = (op == BAX_OP_STORE_ACC) || (!lit_op && instr_i.to_reg); // RULE4
  wire logic wr_acc = fire && res_ok && !to_file; // RULE4
  wire logic wr_file = fire && res_ok && to_file; // RULE4
  wire logic zero_upd = (op == BAX_OP_DEC) || (op == BAX_OP_INC) || (op == BAX_OP_OR_IMM)
    || (op == BAX_OP_OR_REG) || (op == BAX_OP_COPY_REG) || (op == BAX_OP_IMM_SUB)
    || (op == BAX_OP_REG_SUB) || (op == BAX_OP_XOR_IMM) || (op == BAX_OP_XOR_REG);
  wire logic is_ret = (op == BAX_OP_RET_IMM) || (op == BAX_OP_RETURN) || (op == BAX_OP_RET_IRQ);
  wire logic skip_taken = ((op == BAX_OP_DEC_SKIP) || (op == BAX_OP_INC_SKIP)) && res_zero; // RULE3
  wire logic two_cycle = fire && (is_ret || skip_taken); // RULE20
  wire logic standby = fire && (op == BAX_OP_STANDBY);

  // next status: only the bits an operation names move
  bax_status_t next_st;
  always_comb begin
    next_st = st;
    if (fire && zero_upd) begin
      next_st.result_null_flag = res_zero; // RULE23
    end
    if (fire && (op == BAX_OP_ROT_LEFT)) begin
      next_st.carry = opnd[7]; // RULE10
    end
    if (fire && (op == BAX_OP_ROT_RIGHT)) begin
      next_st.carry = opnd[0]; // RULE11
    end
    if (fire && (op == BAX_OP_IMM_SUB)) begin
      next_st.carry = sub_imm[8]; // RULE15
      next_st.half_carry = hc_imm[4];
    end
    if (fire && (op == BAX_OP_REG_SUB)) begin
      next_st.carry = sub_reg[8]; // RULE16
      next_st.half_carry = hc_reg[4];
    end
    if (standby) begin
      next_st.power_down_n = 1'b0; // RULE14
      next_st.watchdog_expiry_n = 1'b1; // RULE14
    end
  end

  // sequencing: flush cycle after returns and taken skips, halt after standby
  always_comb begin
    next_state = state;
    case (state)
      BAX_ST_RUN: begin
        if (standby) begin
          next_state = BAX_ST_HALT; // RULE14
        end else if (two_cycle) begin
          next_state = BAX_ST_FLUSH; // RULE20
        end
      end
      BAX_ST_FLUSH: next_state = BAX_ST_RUN; // RULE24
      BAX_ST_HALT: next_state = wake_i ? BAX_ST_RUN : BAX_ST_HALT;
      default: next_state = BAX_ST_RUN;
    endcase
  end

  // state, accumulator and status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= BAX_ST_RUN;
      acc <= BAX_ACC_RST;
      st <= BAX_STATUS_RST;
    end else begin
      state <= next_state;
      st <= next_st;
      if (wr_acc) begin
        acc <= res;
      end
    end
  end

  // registered side effects; a nop leaves every write, load, pop and clear strobe idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_wr_en_o <= 1'b0;
      reg_wr_addr_o <= 7'h00;
      reg_wr_data_o <= 8'h00;
      pc_load_o <= 1'b0;
      pc_value_o <= BAX_PC_RST;
      stack_pop_o <= 1'b0;
      global_irq_enable_o <= 1'b0;
      watchdog_clear_o <= 1'b0;
    end else begin
      reg_wr_en_o <= wr_file; // RULE4
      reg_wr_addr_o <= instr_i.addr;
      reg_wr_data_o <= res;
      pc_load_o <= fire && is_ret; // RULE12 RULE13 RULE22
      pc_value_o <= stack_head_i;
      stack_pop_o <= fire && is_ret; // RULE13
      if (fire && (op == BAX_OP_RET_IRQ)) begin
        global_irq_enable_o <= 1'b1; // RULE22
      end
      watchdog_clear_o <= standby; // RULE14
    end
  end

  // ready drops for the flush cycle and while halted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_ready_o <= 1'b1;
      halted_o <= 1'b0;
    end else begin
      instr_ready_o <= (next_state == BAX_ST_RUN);
      halted_o <= (next_state == BAX_ST_HALT);
    end
  end

  assign accumulator_reg_o = acc;
  assign status_o = st;

  // a taken skip or a return opens one dead slot, then ready comes back
  sequence s_flush_gap;
    !instr_ready_o ##1 instr_ready_o;
  endsequence

  // standby pulses the watchdog clear once, with the halt level already up
  sequence s_halt_step;
    watchdog_clear_o && halted_o ##1 !watchdog_clear_o;
  endsequence

  chk_skip_flush: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    skip_taken && fire |=> s_flush_gap) else $error("taken skip not two cycles");
  chk_ret_pop: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    fire && is_ret |=> pc_load_o && stack_pop_o && pc_value_o == $past(stack_head_i))
    else $error("return did not load pc");
  chk_standby_bits: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    standby |=> !st.power_down_n && st.watchdog_expiry_n && watchdog_clear_o && halted_o)
    else $error("standby side effects wrong");
  chk_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
    fire && zero_upd |=> st.result_null_flag == $past(res_zero)) else $error("zero flag wrong");
  chk_acc_target: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    fire && res_ok && !to_file |=> acc == $past(res) && !reg_wr_en_o) else $error("acc target wrong");
  chk_file_target: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    fire && res_ok && to_file |=> reg_wr_en_o && reg_wr_data_o == $past(res)) else $error("file target wrong");
  chk_rot_carry: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    fire && op == BAX_OP_ROT_LEFT |=> st.carry == $past(opnd[7])) else $error("rotate carry wrong");
  chk_skip_status: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    fire && (op == BAX_OP_DEC_SKIP || op == BAX_OP_INC_SKIP) |=> $stable(st)) else $error("skip moved status");
  chk_nop_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RULE24
    fire && op == BAX_OP_NOP |=> $stable(acc) && $stable(st) && !reg_wr_en_o && !pc_load_o)
    else $error("nop changed state");
  chk_irq_enable: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
    fire && op == BAX_OP_RET_IRQ |=> global_irq_enable_o) else $error("irq enable not set");
  chk_irq_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
    global_irq_enable_o |=> global_irq_enable_o) else $error("irq enable dropped");

  // sequencing: returns flush one slot, and the flush slot itself changes nothing
  chk_ret_flush: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    fire && is_ret |=> s_flush_gap) else $error("return not two cycles");
  chk_flush_drop: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    state == BAX_ST_FLUSH |=> $stable(acc) && !reg_wr_en_o && !pc_load_o && !stack_pop_o)
    else $error("flush slot executed");
  chk_ret_imm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    fire && op == BAX_OP_RET_IMM |=> acc == $past(instr_i.imm) && pc_load_o) else $error("literal return wrong");

  // standby: halt holds until wake, the watchdog clear is a single pulse
  chk_standby_steps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    standby |=> s_halt_step) else $error("standby sequence wrong");
  chk_halt_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    halted_o && !wake_i |=> halted_o && !instr_ready_o) else $error("halt left without wake");

  // flags worked out from the operands, not from the adder, so a broken adder shows
  chk_rot_right: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    fire && op == BAX_OP_ROT_RIGHT |=> st.carry == $past(opnd[0])) else $error("rotate right carry wrong");
  chk_imm_sub_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
    fire && op == BAX_OP_IMM_SUB |=> acc == 8'($past(instr_i.imm) - $past(acc))
    && st.carry == ($past(instr_i.imm) >= $past(acc))
    && st.half_carry == ($past(instr_i.imm[3:0]) >= $past(acc[3:0]))) else $error("literal subtract wrong");
  chk_reg_sub_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    fire && op == BAX_OP_REG_SUB |=> st.carry == ($past(opnd) >= $past(acc))
    && st.half_carry == ($past(opnd[3:0]) >= $past(acc[3:0]))) else $error("register subtract flags wrong");
  chk_inc_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2 RULE23
    fire && op == BAX_OP_INC |=> st.result_null_flag == ($past(opnd) == 8'hff)) else $error("increment zero wrong");
  chk_dec_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1 RULE23
    fire && op == BAX_OP_DEC |=> st.result_null_flag == ($past(opnd) == 8'h01)) else $error("decrement zero wrong");
  chk_copy_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9 RULE23
    fire && op == BAX_OP_COPY_REG |=> st.result_null_flag == ($past(opnd) == 8'h00)) else $error("copy zero wrong");

  // value checks for the plain logic, arithmetic and move forms
  chk_dec_value: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    fire && op == BAX_OP_DEC && !instr_i.to_reg |=> acc == 8'($past(opnd) - 8'h01)) else $error("decrement wrong");
  chk_inc_file: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2 RULE4
    fire && op == BAX_OP_INC && instr_i.to_reg |=> reg_wr_en_o && reg_wr_data_o == 8'($past(opnd) + 8'h01))
    else $error("increment wrong");
  chk_rot_value: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    fire && op == BAX_OP_ROT_LEFT && !instr_i.to_reg |=> acc == {$past(opnd[6:0]), $past(st.carry)})
    else $error("rotate left value wrong");
  chk_or_imm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    fire && op == BAX_OP_OR_IMM |=> acc == ($past(acc) | $past(instr_i.imm))) else $error("or literal wrong");
  chk_xor_imm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
    fire && op == BAX_OP_XOR_IMM |=> acc == ($past(acc) ^ $past(instr_i.imm))) else $error("xor literal wrong");
  chk_load_imm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    fire && op == BAX_OP_LOAD_IMM |=> acc == $past(instr_i.imm)) else $error("load literal wrong");
  chk_store_acc: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    fire && op == BAX_OP_STORE_ACC |=> reg_wr_en_o && reg_wr_data_o == $past(acc)
    && reg_wr_addr_o == $past(instr_i.addr)) else $error("store accumulator wrong");
  chk_swap_value: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
    fire && op == BAX_OP_SWAP && !instr_i.to_reg |=> acc == {$past(opnd[3:0]), $past(opnd[7:4])})
    else $error("nibble swap wrong");
  chk_quiet_status: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7 RULE8 RULE19
    fire && (op == BAX_OP_LOAD_IMM || op == BAX_OP_STORE_ACC || op == BAX_OP_SWAP) |=> $stable(st))
    else $error("status moved on a quiet op");
  chk_pin_operand: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
    fire && instr_i.is_io && op == BAX_OP_OR_REG && instr_i.to_reg |=> reg_wr_data_o == ($past(acc) | $past(pin_rd_data_i)))
    else $error("io operand not from pins");

endmodule

// file: dv/tb_top.sv
// self-checking bench for the byte alu execute stage
`timescale 1ns/100ps
module tb_top
  import bax_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  bax_instr_t instr = '0;
  logic [7:0] reg_rd = 8'h00;
  logic [7:0] pin_rd = 8'h00;
  logic [12:0] stack_head = 13'h0000;
  logic wake_i = 1'b0;
  logic io_sel = 1'b0;
  logic instr_ready_o, reg_wr_en_o, pc_load_o, stack_pop_o, global_irq_enable_o, watchdog_clear_o, halted_o;
  logic [7:0] accumulator_reg_o, reg_wr_data_o;
  logic [6:0] reg_wr_addr_o;
  logic [12:0] pc_value_o;
  bax_status_t status_o;
  int bad_count = 0;
  int cmp_count = 0;
  bax_byte_alu u_bax_byte_alu (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr),
    .reg_rd_data_i(reg_rd), .pin_rd_data_i(pin_rd), .stack_head_i(stack_head), .wake_i(wake_i),
    .instr_ready_o(instr_ready_o), .accumulator_reg_o(accumulator_reg_o), .status_o(status_o),
    .reg_wr_en_o(reg_wr_en_o), .reg_wr_addr_o(reg_wr_addr_o), .reg_wr_data_o(reg_wr_data_o),
    .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .stack_pop_o(stack_pop_o),
    .global_irq_enable_o(global_irq_enable_o), .watchdog_clear_o(watchdog_clear_o), .halted_o(halted_o));
  // 20 mhz clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one compare for every value kind, widened to the pc width
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [4:0] exp);
    chk(status_o, exp);
  endtask
  // file write pulse always lands on the fixed bench address 05
  task automatic wr(input logic [7:0] exp);
    chk(reg_wr_en_o, 1'b1);
    chk(reg_wr_addr_o, 7'h05);
    chk(reg_wr_data_o, exp);
  endtask
  // offer one instruction; it stays presented, inputs move 1 ns after the edge
  task automatic exec(input bax_op_t op, input logic to_reg, input logic [7:0] rd, input logic [7:0] imm);
    instr.op = op;
    instr.addr = 7'h05;
    instr.to_reg = to_reg;
    instr.imm = imm;
    instr.is_io = io_sel;
    reg_rd = rd;
    instr_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
  endtask
  task automatic idle();
    instr_valid_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset();
    chk(accumulator_reg_o, 8'h00); st(5'h18); chk(instr_ready_o, 1'b1); chk(halted_o, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_logic();
    exec(BAX_OP_LOAD_IMM, 1'b0, 8'h00, 8'h3c); chk(accumulator_reg_o, 8'h3c); st(5'h18);
    exec(BAX_OP_OR_IMM, 1'b0, 8'h00, 8'hc3); chk(accumulator_reg_o, 8'hff); st(5'h18);
    exec(BAX_OP_XOR_IMM, 1'b0, 8'h00, 8'hff); chk(accumulator_reg_o, 8'h00); st(5'h1c);
    exec(BAX_OP_INC, 1'b1, 8'h00, 8'h00); wr(8'h01); st(5'h18);
    exec(BAX_OP_DEC, 1'b0, 8'h01, 8'h00); chk(accumulator_reg_o, 8'h00); st(5'h1c);
    exec(BAX_OP_COPY_REG, 1'b1, 8'h7e, 8'h00); wr(8'h7e); st(5'h18);
    exec(BAX_OP_COPY_REG, 1'b0, 8'h00, 8'h00); chk(reg_wr_en_o, 1'b0); st(5'h1c);
    exec(BAX_OP_OR_REG, 1'b0, 8'h80, 8'h00); chk(accumulator_reg_o, 8'h80); st(5'h18);
    exec(BAX_OP_XOR_REG, 1'b1, 8'h80, 8'h00); wr(8'h00); st(5'h1c);
    chk(accumulator_reg_o, 8'h80);
    $display("test logic done");
  endtask
  // carry starts clear, so the first rotate shows old carry 0 entering
  task automatic t_rotate();
    exec(BAX_OP_ROT_LEFT, 1'b0, 8'h81, 8'h00); chk(accumulator_reg_o, 8'h02); st(5'h1d);
    exec(BAX_OP_ROT_RIGHT, 1'b1, 8'h02, 8'h00); wr(8'h81); st(5'h1c);
    $display("test rotate done");
  endtask
  // carry and half carry read as no-borrow
  task automatic t_sub();
    exec(BAX_OP_REG_SUB, 1'b1, 8'h00, 8'h00); wr(8'hfe); st(5'h18);
    exec(BAX_OP_IMM_SUB, 1'b0, 8'h00, 8'h12); chk(accumulator_reg_o, 8'h10); st(5'h1b);
    exec(BAX_OP_IMM_SUB, 1'b0, 8'h00, 8'h10); chk(accumulator_reg_o, 8'h00); st(5'h1f);
    $display("test subtract done");
  endtask
  task automatic t_move();
    exec(BAX_OP_LOAD_IMM, 1'b0, 8'h00, 8'ha5); chk(accumulator_reg_o, 8'ha5); st(5'h1f);
    exec(BAX_OP_STORE_ACC, 1'b0, 8'h00, 8'h00); wr(8'ha5); st(5'h1f);
    exec(BAX_OP_SWAP, 1'b0, 8'hc3, 8'h00); chk(accumulator_reg_o, 8'h3c); st(5'h1f);
    io_sel = 1'b1;
    pin_rd = 8'h0f;
    exec(BAX_OP_OR_REG, 1'b1, 8'hf0, 8'h00); wr(8'h3f); st(5'h1b);
    io_sel = 1'b0;
    $display("test move done");
  endtask
  // an instruction offered in the flush cycle must be dropped
  task automatic t_skip();
    exec(BAX_OP_DEC_SKIP, 1'b0, 8'h02, 8'h00); chk(accumulator_reg_o, 8'h01); chk(instr_ready_o, 1'b1);
    st(5'h1b);
    exec(BAX_OP_INC_SKIP, 1'b1, 8'hff, 8'h00); wr(8'h00); st(5'h1b); chk(instr_ready_o, 1'b0);
    exec(BAX_OP_LOAD_IMM, 1'b0, 8'h00, 8'h77); chk(accumulator_reg_o, 8'h01); chk(instr_ready_o, 1'b1);
    exec(BAX_OP_LOAD_IMM, 1'b0, 8'h00, 8'h77); chk(accumulator_reg_o, 8'h77);
    // taken decrement skip: zero result lands, zero flag stays clear, one dead slot
    exec(BAX_OP_DEC_SKIP, 1'b0, 8'h01, 8'h00); chk(accumulator_reg_o, 8'h00); st(5'h1b);
    chk(instr_ready_o, 1'b0);
    idle();
    chk(instr_ready_o, 1'b1);
    $display("test skip done");
  endtask
  task automatic t_return();
    stack_head = 13'h0123;
    exec(BAX_OP_RET_IMM, 1'b0, 8'h00, 8'h42); chk(accumulator_reg_o, 8'h42); chk(pc_load_o, 1'b1);
    chk(pc_value_o, 13'h0123); chk(instr_ready_o, 1'b0); st(5'h1b);
    idle();
    stack_head = 13'h1abc;
    exec(BAX_OP_RETURN, 1'b0, 8'h00, 8'h00); chk(pc_value_o, 13'h1abc); chk(stack_pop_o, 1'b1);
    chk(pc_load_o, 1'b1); chk(global_irq_enable_o, 1'b0); chk(instr_ready_o, 1'b0); st(5'h1b);
    idle();
    stack_head = 13'h0555;
    exec(BAX_OP_RET_IRQ, 1'b0, 8'h00, 8'h00); chk(pc_value_o, 13'h0555); chk(stack_pop_o, 1'b1);
    chk(global_irq_enable_o, 1'b1); chk(instr_ready_o, 1'b0); st(5'h1b);
    idle();
    exec(BAX_OP_NOP, 1'b1, 8'h00, 8'h00); chk(accumulator_reg_o, 8'h42); st(5'h1b);
    chk(reg_wr_en_o, 1'b0); chk(pc_load_o, 1'b0); chk(instr_ready_o, 1'b1);
    $display("test return done");
  endtask
  // wake is a bench-driven level; the wait for halt exit is bounded
  task automatic t_standby();
    int n;
    exec(BAX_OP_STANDBY, 1'b0, 8'h00, 8'h00); st(5'h13); chk(watchdog_clear_o, 1'b1);
    chk(halted_o, 1'b1); chk(instr_ready_o, 1'b0);
    idle();
    chk(watchdog_clear_o, 1'b0); chk(halted_o, 1'b1);
    wake_i = 1'b1;
    n = 0;
    while (halted_o !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    wake_i = 1'b0;
    if (n >= 20) begin
      bad_count++;
      stop_test();
    end else begin
      chk(instr_ready_o, 1'b1);
      $display("test standby done");
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_logic();
    t_rotate();
    t_sub();
    t_move();
    t_skip();
    t_return();
    t_standby();
    stop_test();
  end
endmodule
